// ### src/vdma_consts.svh
`ifndef VDMA_CONSTS_SVH
`define VDMA_CONSTS_SVH
`define OFS_CH2_PAGE 8'h28
`define OFS_CH2_WIN 8'h2C
`define OFS_CH3_ODD 8'h30
`define OFS_CH3_EVEN 8'h34
`define OFS_CH3_GUARD 8'h38
`define OFS_CH3_STRIDE 8'h3C
`define OFS_CH3_PAGE 8'h40
`define OFS_CH3_WIN 8'h44
`define OFS_CTRL 8'h48
`define OFS_POINTER 8'h4C
`define MASK_PAGE 32'hFFFFF8FF
`define MASK_GUARD 32'hFFFFFFFC
`define MASK_WIN 32'h0FFF0FFF
`define RST_REG 32'h00000000
`define BIT_ME 11
`define BIT_PV 3
`define BIT_DIR 2
`define BIT_CH3_EN 0
`define BIT_CH2_EN 1
`define WORD_STEP 32'h00000004
`define RANGE_BASE 5
`endif

// ### src/vdma_pkg.sv
package vdma_pkg;
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic wr;
        logic xlat;
        logic [19:0] table_base;
    } pci_req_t;
    typedef struct packed {
        logic [31:0] data;
        logic eol;
    } vid_word_t;
    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_RUN = 4'h2,
        S_DRAIN = 4'h4,
        S_HOLD = 4'h8
    } ch_state_t;
endpackage

// ### src/video_dma_channel_two_three_ctrl.sv
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
`include "vdma_consts.svh"
module video_dma_channel_two_three_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic vid_bof,
    input wire logic vid_odd,
    input wire logic vid_eow,
    input wire logic ch3_in_valid,
    input wire vdma_pkg::vid_word_t ch3_in,
    output logic ch3_in_ready,
    input wire logic ch3_fifo_empty,
    output logic ch3_pci_valid,
    output vdma_pkg::pci_req_t ch3_pci,
    input wire logic ch3_pci_ready,
    input wire logic ch3_rd_valid,
    input wire logic [31:0] ch3_rd_data,
    output logic ch3_out_valid,
    output logic [31:0] ch3_out_data,
    output logic ch3_guard_event,
    output logic ch3_range_event,
    input wire logic ch2_in_valid,
    input wire logic [31:0] ch2_in_data,
    output logic ch2_out_valid,
    output logic [31:0] ch2_out_data,
    input wire logic ch2_fetch_ready,
    output logic ch2_fetch_req,
    output logic ch2_fetch_eol,
    output logic ch2_fetch_done
);
    import vdma_pkg::*;

    function automatic logic [31:0] swap_bytes(input logic [1:0] code, input logic [31:0] d);
        unique case (code)
            2'h1: swap_bytes = {d[23:16], d[31:24], d[7:0], d[15:8]};
            2'h2: swap_bytes = {d[7:0], d[15:8], d[23:16], d[31:24]};
            default: swap_bytes = d;
        endcase
    endfunction

    function automatic logic [31:0] range_mask(input logic [3:0] code);
        range_mask = (32'h00000001 << ({1'b0, code} + 5'(`RANGE_BASE))) - 32'h00000001;
    endfunction

    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [31:0] ch2_page_ctrl, ch2_window_size, ch3_odd_field_start, ch3_even_field_start;
    logic [31:0] ch3_guard_address, ch3_line_stride, ch3_page_ctrl, ch3_window_size;
    logic ch3_en, ch2_en, hw_clear3;
    logic [31:0] ptr, line_start;
    ch_state_t st;
    wire logic wr = psel && penable && pwrite;
    wire logic wr_ctrl = wr && paddr == `OFS_CTRL;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch2_page_ctrl <= `RST_REG;
            ch2_window_size <= `RST_REG;
            ch3_odd_field_start <= `RST_REG;
            ch3_even_field_start <= `RST_REG;
            ch3_guard_address <= `RST_REG;
            ch3_line_stride <= `RST_REG;
            ch3_page_ctrl <= `RST_REG;
            ch3_window_size <= `RST_REG;
        end else if (wr) begin
            unique case (paddr)
                `OFS_CH2_PAGE: ch2_page_ctrl <= pwdata & `MASK_PAGE;
                `OFS_CH2_WIN: ch2_window_size <= pwdata & `MASK_WIN;
                `OFS_CH3_ODD: ch3_odd_field_start <= pwdata;
                `OFS_CH3_EVEN: ch3_even_field_start <= pwdata;
                `OFS_CH3_GUARD: ch3_guard_address <= pwdata & `MASK_GUARD;
                `OFS_CH3_STRIDE: ch3_line_stride <= pwdata;
                `OFS_CH3_PAGE: ch3_page_ctrl <= pwdata & `MASK_PAGE;
                `OFS_CH3_WIN: ch3_window_size <= pwdata & `MASK_WIN;
                default: ;
            endcase
        end
    end

    // Software set wins over the drain clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch3_en <= 1'b0;
            ch2_en <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ch3_en <= pwdata[`BIT_CH3_EN];
                ch2_en <= pwdata[`BIT_CH2_EN];
            end else if (hw_clear3) begin
                ch3_en <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= `RST_REG;
            pready <= 1'b1;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pslverr <= 1'b0;
            unique case (paddr)
                `OFS_CH2_PAGE: prdata <= ch2_page_ctrl;
                `OFS_CH2_WIN: prdata <= ch2_window_size;
                `OFS_CH3_ODD: prdata <= ch3_odd_field_start;
                `OFS_CH3_EVEN: prdata <= ch3_even_field_start;
                `OFS_CH3_GUARD: prdata <= ch3_guard_address;
                `OFS_CH3_STRIDE: prdata <= ch3_line_stride;
                `OFS_CH3_PAGE: prdata <= ch3_page_ctrl;
                `OFS_CH3_WIN: prdata <= ch3_window_size;
                `OFS_CTRL: prdata <= {24'h000000, 4'(st), 2'h0, ch2_en, ch3_en};
                `OFS_POINTER: prdata <= ptr;
                default: begin
                    prdata <= `RST_REG;
                    pslverr <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Channel 3 sequencer
    // ----------------------------------------
    wire logic dir3 = ch3_page_ctrl[`BIT_DIR];
    wire logic pv3 = ch3_page_ctrl[`BIT_PV];
    wire logic [3:0] lim3 = ch3_page_ctrl[7:4];
    wire logic [1:0] ch3_byte_order = ch3_page_ctrl[1:0];
    wire logic [11:0] nl3 = ch3_window_size[27:16];
    wire logic [9:0] nw3 = ch3_window_size[11:2];
    wire logic [31:0] base3 = vid_odd ? ch3_odd_field_start : ch3_even_field_start;
    wire logic [31:0] first3 = ch3_line_stride[31] ? base3 + ch3_line_stride : base3;
    wire logic hit = ptr[31:2] >= ch3_guard_address[31:2];
    wire logic free = !ch3_pci_valid || ch3_pci_ready;
    wire logic take = st == S_RUN && !dir3 && ch3_in_valid && ch3_in_ready;
    wire logic fetch = st == S_RUN && dir3 && free;
    logic [9:0] w3;
    logic [11:0] l3;
    wire logic keep = w3 <= nw3 && l3 <= nl3;
    wire logic issue = (take && keep) || fetch;
    wire logic guard_hit = issue && hit;
    wire logic [31:0] ptr_nx = ptr + `WORD_STEP;
    wire logic line_end = fetch ? w3 == nw3 : take && ch3_in.eol;
    wire logic field_end = fetch && w3 == nw3 && l3 == nl3;
    wire logic [31:0] ls_nx = line_start + ch3_line_stride;

    assign hw_clear3 = st == S_DRAIN && ch3_fifo_empty;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= S_IDLE;
            ptr <= `RST_REG;
            line_start <= `RST_REG;
            w3 <= 10'h000;
            l3 <= 12'h000;
        end else if (!ch3_en) begin
            st <= S_IDLE;
        end else begin
            unique case (st)
                S_IDLE: begin
                    if (vid_bof) begin
                        st <= S_RUN;
                        ptr <= first3;
                        line_start <= first3;
                        w3 <= 10'h000;
                        l3 <= 12'h000;
                    end
                end
                S_RUN: begin
                    if (guard_hit) begin
                        if (pv3) begin
                            st <= S_DRAIN;
                        end else if (lim3 == 4'h0) begin
                            st <= S_HOLD;
                        end else begin
                            ptr <= first3;
                            line_start <= first3;
                            w3 <= 10'h000;
                            l3 <= 12'h000;
                        end
                    end else if (line_end) begin
                        ptr <= ls_nx;
                        line_start <= ls_nx;
                        w3 <= 10'h000;
                        l3 <= l3 + 12'h001;
                        if (field_end) begin
                            st <= S_IDLE;
                        end
                    end else if (issue) begin
                        ptr <= ptr_nx;
                        w3 <= w3 + 10'h001;
                    end else if (take) begin
                        w3 <= (w3 == 10'h3FF) ? w3 : w3 + 10'h001;
                    end
                end
                S_DRAIN: begin
                    if (ch3_fifo_empty) begin
                        st <= S_IDLE;
                    end
                end
                S_HOLD: begin
                    if (vid_eow) begin
                        st <= S_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch3_in_ready <= 1'b0;
        end else begin
            ch3_in_ready <= ch3_en && st == S_RUN && !dir3 && !take && free && !guard_hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch3_pci_valid <= 1'b0;
            ch3_pci <= '0;
        end else if (issue && !hit) begin
            ch3_pci_valid <= 1'b1;
            ch3_pci.addr <= ptr;
            ch3_pci.data <= swap_bytes(ch3_byte_order, ch3_in.data);
            ch3_pci.wr <= !dir3;
            ch3_pci.xlat <= ch3_page_ctrl[`BIT_ME];
            ch3_pci.table_base <= ch3_page_ctrl[31:12];
        end else if (ch3_pci_ready) begin
            ch3_pci_valid <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch3_guard_event <= 1'b0;
            ch3_range_event <= 1'b0;
        end else begin
            ch3_guard_event <= guard_hit;
            ch3_range_event <= issue && !hit && lim3 != 4'h0 &&
                (ptr_nx & range_mask(lim3)) == 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch3_out_valid <= 1'b0;
            ch3_out_data <= `RST_REG;
        end else begin
            ch3_out_valid <= ch3_rd_valid && dir3;
            ch3_out_data <= swap_bytes(ch3_byte_order, ch3_rd_data);
        end
    end

    // ----------------------------------------
    // Channel 2 data path and fetch counter
    // ----------------------------------------
    wire logic dir2 = ch2_page_ctrl[`BIT_DIR];
    wire logic [11:0] nl2 = ch2_window_size[27:16];
    wire logic [9:0] nw2 = ch2_window_size[11:2];
    logic [9:0] w2;
    logic [11:0] l2;
    logic run2;
    wire logic go2 = run2 && ch2_fetch_ready && !ch2_fetch_req;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch2_out_valid <= 1'b0;
            ch2_out_data <= `RST_REG;
        end else begin
            ch2_out_valid <= ch2_in_valid;
            ch2_out_data <= swap_bytes(ch2_page_ctrl[1:0], ch2_in_data);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run2 <= 1'b0;
            w2 <= 10'h000;
            l2 <= 12'h000;
            ch2_fetch_req <= 1'b0;
            ch2_fetch_eol <= 1'b0;
            ch2_fetch_done <= 1'b0;
        end else begin
            ch2_fetch_req <= go2;
            ch2_fetch_eol <= go2 && w2 == nw2;
            ch2_fetch_done <= go2 && w2 == nw2 && l2 == nl2;
            if (!ch2_en || !dir2) begin
                run2 <= 1'b0;
            end else if (!run2 && vid_bof) begin
                run2 <= 1'b1;
                w2 <= 10'h000;
                l2 <= 12'h000;
            end else if (go2) begin
                if (w2 == nw2) begin
                    w2 <= 10'h000;
                    l2 <= l2 + 12'h001;
                    run2 <= l2 != nl2;
                end else begin
                    w2 <= w2 + 10'h001;
                end
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_CH2_BYTE_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
        ch2_in_valid && ch2_page_ctrl[1:0] == 2'h2 |=>
        ch2_out_data == {$past(ch2_in_data[7:0]), $past(ch2_in_data[15:8]),
        $past(ch2_in_data[23:16]), $past(ch2_in_data[31:24])})
        else $error("ch2 byte reversal wrong");
    AST_GUARD_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
        guard_hit |=> ch3_guard_event && !($rose(ch3_pci_valid)))
        else $error("guard hit not reported or word issued");
    AST_DRAIN: assert property (@(posedge pclk) disable iff (!presetn)
        guard_hit && pv3 && ch3_en && !wr_ctrl |=> st == S_DRAIN && !ch3_in_ready)
        else $error("policy hit did not lock and drain");
    AST_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        hw_clear3 && !wr_ctrl |=> !ch3_en ##1 st == S_IDLE)
        else $error("enable not cleared after drain");
    AST_NEG_STRIDE: assert property (@(posedge pclk) disable iff (!presetn)
        st == S_IDLE && ch3_en && vid_bof |=>
        ptr == $past(base3) + ($past(ch3_line_stride[31]) ? $past(ch3_line_stride) : 32'h0))
        else $error("first line address wrong");
    AST_XLAT: assert property (@(posedge pclk) disable iff (!presetn)
        issue && !hit |=> ch3_pci_valid && ch3_pci.xlat == $past(ch3_page_ctrl[11]))
        else $error("translation flag wrong");
    AST_STRIDE: assert property (@(posedge pclk) disable iff (!presetn)
        st == S_RUN && ch3_en && line_end && !guard_hit |=>
        ptr == $past(line_start) + $past(ch3_line_stride))
        else $error("line stride not applied");
    AST_FETCH_DONE: assert property (@(posedge pclk) disable iff (!presetn)
        ch2_fetch_done |-> ch2_fetch_eol && !run2)
        else $error("ch2 fetch did not stop at last line");
endmodule

// ### bench/pci_path_model.sv
`timescale 1ns/100ps
module pci_path_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic ch3_pci_valid,
    input wire vdma_pkg::pci_req_t ch3_pci,
    output logic ch3_pci_ready,
    output logic ch3_rd_valid,
    output logic [31:0] ch3_rd_data
);
    import vdma_pkg::*;
    // ----
    // Accept with optional stall, return fetched words
    // ----
    logic [1:0] wait_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch3_pci_ready <= 1'b0;
            ch3_rd_valid <= 1'b0;
            ch3_rd_data <= 32'h00000000;
            wait_cnt <= 2'h0;
        end else begin
            ch3_rd_valid <= 1'b0;
            ch3_rd_data <= ~ch3_rd_data;
            ch3_pci_ready <= 1'b0;
            if (ch3_pci_valid && !ch3_pci_ready) begin
                if (wait_cnt == (slow ? 2'h3 : 2'h0)) begin
                    ch3_pci_ready <= 1'b1;
                    wait_cnt <= 2'h0;
                end else begin
                    wait_cnt <= wait_cnt + 2'h1;
                end
            end
            if (ch3_pci_valid && ch3_pci_ready && !ch3_pci.wr) begin
                ch3_rd_valid <= 1'b1;
                ch3_rd_data <= ch3_pci.addr ^ 32'hC3C30000;
            end
        end
    end
endmodule

// ### bench/video_dma_channel_two_three_ctrl_test.sv
`timescale 1ns/100ps
`include "vdma_consts.svh"
module video_dma_channel_two_three_ctrl_test;
    import vdma_pkg::*;
    // ----
    // Signals
    // ----
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, slow = 0;
    logic vid_bof = 0, vid_odd = 0, vid_eow = 0, ch3_in_valid = 0, ch3_in_ready;
    logic ch3_fifo_empty = 0, ch3_pci_valid, ch3_pci_ready, ch3_rd_valid, ch3_out_valid;
    logic ch3_guard_event, ch3_range_event, ch2_in_valid = 0, ch2_out_valid, e;
    logic ch2_fetch_ready = 0, ch2_fetch_req, ch2_fetch_eol, ch2_fetch_done;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, ch3_rd_data, ch3_out_data, ch2_in_data = 0, ch2_out_data;
    logic [31:0] r, mdl [int];
    logic [31:0] qa [$], qd [$], qo [$], q2 [$], w [$];
    vid_word_t ch3_in = '0;
    pci_req_t ch3_pci, last;
    int n_errors = 0, checked = 0, seed = 64151, cyc = 0, n_grd, n_rng, n_req, n_eol, n_done;
    video_dma_channel_two_three_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .vid_bof, .vid_odd, .vid_eow,
        .ch3_in_valid, .ch3_in, .ch3_in_ready, .ch3_fifo_empty, .ch3_pci_valid, .ch3_pci,
        .ch3_pci_ready, .ch3_rd_valid, .ch3_rd_data, .ch3_out_valid, .ch3_out_data,
        .ch3_guard_event, .ch3_range_event, .ch2_in_valid, .ch2_in_data, .ch2_out_valid,
        .ch2_out_data, .ch2_fetch_ready, .ch2_fetch_req, .ch2_fetch_eol, .ch2_fetch_done);
    pci_path_model u_pci (.pclk, .presetn, .slow, .ch3_pci_valid, .ch3_pci, .ch3_pci_ready,
        .ch3_rd_valid, .ch3_rd_data);
    initial begin
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            results();
        end
        if (ch3_pci_valid === 1'b1 && ch3_pci_ready === 1'b1) begin
            qa.push_back(ch3_pci.addr);
            qd.push_back(ch3_pci.data);
            last = ch3_pci;
        end
        if (ch3_out_valid === 1'b1) qo.push_back(ch3_out_data);
        if (ch2_out_valid === 1'b1) q2.push_back(ch2_out_data);
        n_grd += (ch3_guard_event === 1'b1);
        n_rng += (ch3_range_event === 1'b1);
        n_req += (ch2_fetch_req === 1'b1);
        n_eol += (ch2_fetch_eol === 1'b1);
        n_done += (ch2_fetch_done === 1'b1);
    end
    // ----
    // Tasks
    // ----
    task results();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] x, input logic [31:0] got);
        checked++;
        if (got !== x) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, x, got);
        end
    endtask
    task rst();
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        qa.delete();
        qd.delete();
        qo.delete();
        w.delete();
        {n_grd, n_rng, n_req, n_eol, n_done} = '0;
    endtask
    function logic [31:0] msk(input logic [7:0] a);
        case (a)
            `OFS_CH2_PAGE, `OFS_CH3_PAGE: msk = `MASK_PAGE;
            `OFS_CH3_GUARD: msk = `MASK_GUARD;
            `OFS_CH2_WIN, `OFS_CH3_WIN: msk = `MASK_WIN;
            default: msk = 32'hFFFFFFFF;
        endcase
    endfunction
    function logic [31:0] swp(input logic [1:0] c, input logic [31:0] d);
        case (c)
            2'h1: swp = {d[23:16], d[31:24], d[7:0], d[15:8]};
            2'h2: swp = {d[7:0], d[15:8], d[23:16], d[31:24]};
            default: swp = d;
        endcase
    endfunction
    task apb(input logic wn, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wn;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        mdl[a] = d & msk(a);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h00000000);
        chk("prdata", x, r);
    endtask
    task cfg3(input logic [31:0] pg, wn, od, ev, gd, st);
        wr(`OFS_CH3_PAGE, pg);
        wr(`OFS_CH3_WIN, wn);
        wr(`OFS_CH3_ODD, od);
        wr(`OFS_CH3_EVEN, ev);
        wr(`OFS_CH3_GUARD, gd);
        wr(`OFS_CH3_STRIDE, st);
    endtask
    task send(input logic [31:0] d, input logic eol);
        @(posedge pclk);
        ch3_in <= '{data: d, eol: eol};
        ch3_in_valid <= 1'b1;
        @(posedge pclk);
        while (ch3_in_ready !== 1'b1) @(posedge pclk);
        ch3_in_valid <= 1'b0;
    endtask
    task bof(input logic odd);
        @(posedge pclk);
        vid_odd <= odd;
        vid_bof <= 1'b1;
        @(posedge pclk);
        vid_bof <= 1'b0;
    endtask
    task waitq(input int n);
        while (qa.size() < n) @(posedge pclk);
        repeat (12) @(posedge pclk);
    endtask
    // ----
    // Sequence
    // ----
    initial begin
        rst();
        for (int a = 8'h28; a <= 8'h44; a += 4) begin
            rd(a[7:0], `RST_REG);
            wr(a[7:0], $random(seed));
            rd(a[7:0], mdl[a]);
        end
        apb(1'b0, 8'hF0, 32'h00000000);
        chk("unmapped_err", 32'h1, {31'h0, e});
        chk("unmapped_data", 32'h0, r);
        for (int c = 0; c < 4; c++) begin
            wr(`OFS_CH2_PAGE, c);
            w.push_back($random(seed));
            @(posedge pclk);
            ch2_in_valid <= 1'b1;
            ch2_in_data <= w[c];
            @(posedge pclk);
            ch2_in_valid <= 1'b0;
            repeat (3) @(posedge pclk);
            chk("ch2_out", swp(c[1:0], w[c]), q2[c]);
        end
        $display("registers and ch2 swap done");
        rst();
        slow <= 1'b1;
        cfg3(32'hABCDE811, 32'h00010007, 32'h1038, 32'h9000, 32'hFFFFFFFC, 32'h100);
        wr(`OFS_CTRL, 32'h1);
        bof(1'b1);
        for (int i = 0; i < 6; i++) begin
            w.push_back($random(seed));
            send(w[i], i == 2 || i >= 4);
        end
        waitq(4);
        chk("pci_count", 4, qa.size());
        for (int i = 0; i < 4; i++) begin
            chk("pci_addr", 32'h1038 + (i / 2) * 32'h100 + (i % 2) * 4, qa[i]);
            chk("pci_data", swp(2'h1, w[i < 2 ? i : i + 1]), qd[i]);
        end
        chk("pci_ctl", {20'hABCDE, 12'h3}, {last.table_base, 10'h0, last.xlat, last.wr});
        chk("range_events", 2, n_rng);
        $display("ch3 write done");
        rst();
        cfg3(32'h0000000A, 32'h00010007, 32'h1000, 32'h9000, 32'h8F07, 32'hFFFFFF00);
        wr(`OFS_CTRL, 32'h1);
        bof(1'b0);
        for (int i = 0; i < 2; i++) begin
            w.push_back($random(seed));
            send(w[i], 1'b0);
        end
        waitq(1);
        chk("guard_events", 1, n_grd);
        chk("pci_count", 1, qa.size());
        chk("pci_addr", 32'h8F00, qa[0]);
        chk("pci_data", swp(2'h2, w[0]), qd[0]);
        rd(`OFS_CTRL, 32'h41);
        ch3_fifo_empty <= 1'b1;
        repeat (4) @(posedge pclk);
        rd(`OFS_CTRL, 32'h10);
        $display("ch3 guard done");
        rst();
        slow <= 1'b0;
        cfg3(32'h00000005, 32'h00010004, 32'h2000, 32'h0, 32'hFFFFFFFC, 32'h40);
        wr(`OFS_CH2_PAGE, 32'h4);
        wr(`OFS_CH2_WIN, 32'h00020003);
        wr(`OFS_CTRL, 32'h3);
        ch2_fetch_ready <= 1'b1;
        bof(1'b1);
        waitq(4);
        chk("pci_count", 4, qa.size());
        for (int i = 0; i < 4; i++) begin
            logic [31:0] a;
            a = 32'h2000 + (i / 2) * 32'h40 + (i % 2) * 4;
            chk("pci_addr", a, qa[i]);
            chk("out_data", swp(2'h1, a ^ 32'hC3C30000), qo[i]);
        end
        chk("pci_wr", 0, last.wr);
        chk("ch2_req", 3, n_req);
        chk("ch2_eol", 3, n_eol);
        chk("ch2_done", 1, n_done);
        $display("fetch done");
        results();
    end
endmodule
